// ---- bench/ocl_host_model.sv ----
// Host side of the decoded command port: one request at a time, answer taken one cycle on
module ocl_host_model (
  // Clock
  input  wire logic        i_clk,
  // Request
  output logic             o_valid,
  output logic             o_write,
  output logic [7:0]       o_code,
  output logic [7:0]       o_phase,
  output logic [15:0]      o_wdata,
  // Answer
  input  wire logic        i_done,
  input  wire logic        i_nack,
  input  wire logic        i_silent,
  input  wire logic [15:0] i_rdata
);
  timeunit 1ns;
  timeprecision 1ps;
  logic        got_done;
  logic        got_nack;
  logic        got_silent;
  logic [15:0] got_rdata;
  // Idle request lines from time zero
  initial
  begin
    o_valid = 1'b0;
    o_write = 1'b0;
    o_code  = 8'h00;
    o_phase = 8'h00;
    o_wdata = 16'h0000;
  end
  // Raised after an edge, taken at the next, answer sampled once that edge has landed
  task automatic xfer(input logic w, input logic [7:0] c, input logic [7:0] p, input logic [15:0] d);
    @(posedge i_clk);
    #1;
    o_valid = 1'b1;
    o_write = w;
    o_code  = c;
    o_phase = p;
    o_wdata = d;
    @(posedge i_clk);
    #1;
    o_valid = 1'b0;
    o_wdata = ~d; // Released data shows no stale value
    got_done   = i_done;
    got_nack   = i_nack;
    got_silent = i_silent;
    got_rdata  = i_rdata;
  endtask
endmodule

// ---- bench/ocl_limit_cmd_bench.sv ----
module ocl_limit_cmd_bench;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int D64 = 20;
  localparam int D256 = 30;
  localparam int HIC = 50;
  logic i_clk = 1'b0;
  logic i_reset = 1'b1;
  logic [1:0] ph = ocl_pkg::PH_FOUR;
  logic prim = 1'b1;
  logic [15:0] uvl = 16'h0000;
  logic [7:0] uvr = 8'h00;
  logic [7:0] vm = 8'h00;
  logic rst = 1'b0;
  logic [3:0] lvl = 4'h0;
  logic incl = 1'b0;
  logic below = 1'b0;
  logic clr = 1'b0;
  logic v, w, done, nack, sil, off, cml, ivd, oc, iout, ocuv, al_o, al_e;
  logic [7:0] code, phs, lmode;
  logic [15:0] wd, rdat, thr;
  logic [3:0] ocl;
  int err_count = 0;
  int num_checks = 0;
  int n;
  int bnd[14] = '{10, 14, 17, 22, 25, 28, 33, 37, 39, 42, 47, 50, 53, 58};
  int stk[14] = '{0, 42, 51, 64, 75, 85, 98, 109, 117, 126, 139, 148, 158, 173};
  int s2[2] = '{49, 27};
  int s4[2] = '{64, 69};
  ocl_host_model host (.i_clk(i_clk), .o_valid(v), .o_write(w), .o_code(code), .o_phase(phs),
    .o_wdata(wd), .i_done(done), .i_nack(nack), .i_silent(sil), .i_rdata(rdat));
  ocl_limit_cmd #(.DLY64_CYC(D64), .DLY256_CYC(D256), .HICCUP_CYC(HIC)) dut (
    .i_clk(i_clk), .i_reset(i_reset), .i_cmd_valid(v), .i_cmd_write(w), .i_cmd_code(code),
    .i_cmd_phase(phs), .i_cmd_wdata(wd), .o_cmd_done(done), .o_cmd_nack(nack), .o_cmd_silent(sil),
    .o_cmd_rdata(rdat), .i_phase_count(ph), .i_is_primary(prim), .i_uv_fault_limit(uvl),
    .i_uv_response(uvr), .i_vout_mode(vm), .i_nvm_restore(rst), .i_nvm_level(lvl),
    .i_in_current_limit(incl), .i_vout_below_lv(below), .i_clear_faults(clr), .o_oc_level(ocl),
    .o_lv_threshold(thr), .o_lv_mode(lmode), .o_output_off(off), .o_status_cml(cml),
    .o_status_ivd(ivd), .o_status_oc(oc), .o_status_iout(iout), .o_status_ocuv(ocuv),
    .o_smbalert_n_out(al_o), .o_smbalert_n_oe(al_e));
  // Free running clock, 10 ns
  always #5 i_clk = ~i_clk;
  task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string m);
    num_checks++;
    if (got !== exp)
    begin
      err_count++;
      $display("mismatch at %0t: %s got %h expected %h", $time, m, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] c, input logic [7:0] p, input logic [15:0] d, input logic nk);
    host.xfer(1'b1, c, p, d);
    chk({14'h0000, host.got_done, host.got_nack}, {14'h0000, 1'b1, nk}, "write answer");
  endtask
  task automatic rd(input logic [7:0] c, input logic [7:0] p, input logic [15:0] e);
    host.xfer(1'b0, c, p, 16'h0000);
    chk({host.got_done, host.got_rdata[14:0]}, {1'b1, e[14:0]}, "read data");
  endtask
  task automatic flags(input logic [4:0] e);
    chk({11'h000, cml, ivd, oc, iout, ocuv}, {11'h000, e}, "status flags");
  endtask
  // One-cycle pulse on the clear or restore strobe
  task automatic pulse(input logic is_clr);
    @(posedge i_clk);
    #1;
    if (is_clr) clr = 1'b1;
    else rst = 1'b1;
    @(posedge i_clk);
    #1;
    clr = 1'b0;
    rst = 1'b0;
  endtask
  task automatic give_verdict;
    if (err_count == 0 && num_checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  // Whole run needs well under this span
  initial
  begin
    #500000;
    err_count++;
    give_verdict();
  end
  // Main sequence
  initial
  begin
    repeat (2) @(posedge i_clk);
    #1;
    i_reset = 1'b0;
    rd(8'h46, 8'h00, 16'h001C);
    chk({12'h000, ocl}, 16'h0005, "reset band");
    for (int i = 1; i < 14; i++)
    begin
      wr(8'h46, 8'h00, 16'(bnd[i] - 1), 1'b0);
      chk({12'h000, ocl}, 16'(i - 1), "band below");
      wr(8'h46, 8'h00, 16'(bnd[i]), 1'b0);
      rd(8'h46, 8'h00, 16'(bnd[i]));
      chk({12'h000, ocl}, 16'(i), "band at bound");
    end
    // Canonical mantissa per restored band
    for (int i = 0; i < 14; i++)
    begin
      lvl = 4'(i);
      pulse(1'b0);
      rd(8'h46, 8'h00, 16'(bnd[i]));
    end
    // Refusals depend on the phase count
    ph = ocl_pkg::PH_ONE;
    wr(8'h46, 8'h00, 16'h0020, 1'b0);
    wr(8'h46, 8'h00, 16'h0120, 1'b1);
    rd(8'h46, 8'h00, 16'h0020);
    flags(5'h18);
    pulse(1'b1);
    flags(5'h00);
    wr(8'h46, 8'h00, 16'h0060, 1'b1);
    ph = ocl_pkg::PH_TWO;
    wr(8'h46, 8'h00, 16'h0060, 1'b0);
    wr(8'h46, 8'h00, 16'h00A0, 1'b1);
    ph = ocl_pkg::PH_THREE;
    wr(8'h46, 8'h00, 16'h00A0, 1'b0);
    rd(8'h46, 8'h00, 16'h00A0);
    // Three phases: stack table, each bound and one below it
    for (int i = 1; i < 14; i++)
    begin
      wr(8'h46, 8'hFF, 16'(stk[i] - 1), 1'b0);
      rd(8'h46, 8'h00, 16'(bnd[i - 1]));
      wr(8'h46, 8'hFF, 16'(stk[i]), 1'b0);
      rd(8'h46, 8'h00, 16'(bnd[i]));
      rd(8'h46, 8'hFF, 16'(bnd[i] * 3));
    end
    // Two and four phases: division rounded up for two, to nearest for four, then product on readback
    for (int i = 0; i < 2; i++)
    begin
      ph = ocl_pkg::PH_TWO;
      wr(8'h46, 8'hFF, 16'(s2[i]), 1'b0);
      rd(8'h46, 8'h00, 16'((s2[i] + 1) >> 1));
      rd(8'h46, 8'hFF, 16'(((s2[i] + 1) >> 1) * 2));
      ph = ocl_pkg::PH_FOUR;
      wr(8'h46, 8'hFF, 16'(s4[i]), 1'b0);
      rd(8'h46, 8'h00, 16'((s4[i] + 2) >> 2));
      rd(8'h46, 8'hFF, 16'(((s4[i] + 2) >> 2) * 4));
    end
    chk({12'h000, ocl}, 16'h0002, "four phase band");
    prim = 1'b0;
    host.xfer(1'b0, 8'h46, 8'hFF, 16'h0000);
    chk({host.got_done, host.got_silent, host.got_rdata[13:0]}, 16'hC000, "secondary read");
    prim = 1'b1;
    // Read-only mirrors of the undervoltage settings
    uvl = 16'h1234;
    vm = 8'h17;
    uvr = 8'h5A;
    rd(8'h48, 8'h00, 16'h1234);
    chk(thr, 16'h1234, "threshold copy");
    chk({8'h00, lmode}, 16'h0017, "mode copy");
    wr(8'h48, 8'h00, 16'hFFFF, 1'b1);
    rd(8'h48, 8'h00, 16'h1234);
    wr(8'h49, 8'h00, 16'h0000, 1'b1);
    rd(8'h49, 8'h00, 16'h005A);
    pulse(1'b1);
    chk({15'h0000, al_e}, 16'h0000, "alert idle");
    // Short dip below the threshold clears the persistence count
    uvr = 8'h42;
    incl = 1'b1;
    below = 1'b1;
    repeat (D64 - 5) @(posedge i_clk);
    #1;
    below = 1'b0;
    repeat (D64 + 5) @(posedge i_clk);
    #1;
    flags(5'h00);
    below = 1'b1;
    n = 0;
    while (oc !== 1'b1 && n < 200)
    begin
      @(posedge i_clk);
      #1;
      n++;
    end
    chk(16'(n >= D64 && n <= D64 + 4), 16'h0001, "fault delay");
    flags(5'h07);
    chk({13'h0000, al_e, al_o, off}, 16'h0005, "alert and off");
    below = 1'b0;
    repeat (HIC + 10) @(posedge i_clk);
    #1;
    chk({15'h0000, off}, 16'h0001, "latched off");
    pulse(1'b1);
    flags(5'h00);
    chk({14'h0000, al_e, off}, 16'h0000, "cleared");
    // Hiccup restart after the 52 ms stand-in
    uvr = 8'h7B;
    below = 1'b1;
    n = 0;
    while (oc !== 1'b1 && n < 200)
    begin
      @(posedge i_clk);
      #1;
      n++;
    end
    below = 1'b0;
    chk(16'(n >= D256 && n <= D256 + 4), 16'h0001, "long delay");
    n = 0;
    while (off !== 1'b0 && n < 300)
    begin
      @(posedge i_clk);
      #1;
      n++;
    end
    chk(16'(n >= HIC - 5 && n <= HIC + 6), 16'h0001, "hiccup time");
    pulse(1'b1);
    // No fault when ignored or when not current limiting
    uvr = 8'h3A;
    below = 1'b1;
    repeat (3 * D64) @(posedge i_clk);
    #1;
    uvr = 8'h42;
    incl = 1'b0;
    repeat (3 * D64) @(posedge i_clk);
    #1;
    flags(5'h00);
    give_verdict();
  end
endmodule

// ---- verilog/ocl_limit_cmd.sv ----
module ocl_limit_cmd #(
  parameter int DLY64_CYC  = ocl_pkg::DLY_64US_CYC,
  parameter int DLY256_CYC = ocl_pkg::DLY_256US_CYC,
  parameter int HICCUP_CYC = ocl_pkg::HICCUP_CYC
) (
  // Clock and reset
  input  wire logic        i_clk,
  input  wire logic        i_reset,
  // Decoded command port
  input  wire logic        i_cmd_valid,
  input  wire logic        i_cmd_write,
  input  wire logic [7:0]  i_cmd_code,
  input  wire logic [7:0]  i_cmd_phase,
  input  wire logic [15:0] i_cmd_wdata,
  output logic             o_cmd_done,
  output logic             o_cmd_nack,
  output logic             o_cmd_silent,
  output logic [15:0]      o_cmd_rdata,
  // Configuration and mirrored sources
  input  wire logic [1:0]  i_phase_count,
  input  wire logic        i_is_primary,
  input  wire logic [15:0] i_uv_fault_limit,
  input  wire logic [7:0]  i_uv_response,
  input  wire logic [7:0]  i_vout_mode,
  input  wire logic        i_nvm_restore,
  input  wire logic [3:0]  i_nvm_level,
  // Fault inputs
  input  wire logic        i_in_current_limit,
  input  wire logic        i_vout_below_lv,
  input  wire logic        i_clear_faults,
  // Applied settings
  output logic [3:0]       o_oc_level,
  output logic [15:0]      o_lv_threshold,
  output logic [7:0]       o_lv_mode,
  output logic             o_output_off,
  // Status flags
  output logic             o_status_cml,
  output logic             o_status_ivd,
  output logic             o_status_oc,
  output logic             o_status_iout,
  output logic             o_status_ocuv,
  // Alert pin, open drain
  output logic             o_smbalert_n_out,
  output logic             o_smbalert_n_oe
);
  // Band index of the single-phase table
  function automatic logic [3:0] bin_phase(input logic [8:0] v);
    logic [3:0] r;
    r = 4'h0;
    if (v >= 9'd14) r = 4'h1;
    if (v >= 9'd17) r = 4'h2;
    if (v >= 9'd22) r = 4'h3;
    if (v >= 9'd25) r = 4'h4;
    if (v >= 9'd28) r = 4'h5;
    if (v >= 9'd33) r = 4'h6;
    if (v >= 9'd37) r = 4'h7;
    if (v >= 9'd39) r = 4'h8;
    if (v >= 9'd42) r = 4'h9;
    if (v >= 9'd47) r = 4'hA;
    if (v >= 9'd50) r = 4'hB;
    if (v >= 9'd53) r = 4'hC;
    if (v >= 9'd58) r = 4'hD;
    return r;
  endfunction

  // Band index of the three-phase stack table
  function automatic logic [3:0] bin_stack3(input logic [7:0] v);
    logic [3:0] r;
    r = 4'h0;
    if (v >= 8'd42)  r = 4'h1;
    if (v >= 8'd51)  r = 4'h2;
    if (v >= 8'd64)  r = 4'h3;
    if (v >= 8'd75)  r = 4'h4;
    if (v >= 8'd85)  r = 4'h5;
    if (v >= 8'd98)  r = 4'h6;
    if (v >= 8'd109) r = 4'h7;
    if (v >= 8'd117) r = 4'h8;
    if (v >= 8'd126) r = 4'h9;
    if (v >= 8'd139) r = 4'hA;
    if (v >= 8'd148) r = 4'hB;
    if (v >= 8'd158) r = 4'hC;
    if (v >= 8'd173) r = 4'hD;
    return r;
  endfunction

  // Canonical mantissa per band: the band's lower bound, first band 10
  function automatic logic [7:0] canon(input logic [3:0] idx);
    logic [7:0] r;
    case (idx)
      4'h0:    r = 8'h0A;
      4'h1:    r = 8'h0E;
      4'h2:    r = 8'h11;
      4'h3:    r = 8'h16;
      4'h4:    r = 8'h19;
      4'h5:    r = 8'h1C;
      4'h6:    r = 8'h21;
      4'h7:    r = 8'h25;
      4'h8:    r = 8'h27;
      4'h9:    r = 8'h2A;
      4'hA:    r = 8'h2F;
      4'hB:    r = 8'h32;
      4'hC:    r = 8'h35;
      default: r = 8'h3A;
    endcase
    return r;
  endfunction

  logic [7:0]              mant_ff;
  logic [7:0]              nxt_mant;
  logic                    done_ff;
  logic                    nack_ff;
  logic                    silent_ff;
  logic [15:0]             rdata_ff;
  logic                    cml_ff;
  logic                    ivd_ff;
  logic                    oc_ff;
  logic                    iout_ff;
  logic                    ocuv_ff;
  logic [31:0]             cnt_ff;
  logic [31:0]             nxt_cnt;
  ocl_pkg::ocl_state_type  state_ff;
  ocl_pkg::ocl_state_type  nxt_state;

  // Phase-count decode
  wire        ph1       = (i_phase_count == ocl_pkg::PH_ONE);
  wire        ph2       = (i_phase_count == ocl_pkg::PH_TWO);
  wire        ph3       = (i_phase_count == ocl_pkg::PH_THREE);
  wire        ph4       = (i_phase_count == ocl_pkg::PH_FOUR);
  wire [2:0]  ph_mult   = ph4 ? 3'd4 : {1'b0, i_phase_count};

  // Command decode
  wire        hit_lim   = i_cmd_valid && (i_cmd_code == ocl_pkg::CMD_OC_FAULT_LIMIT);
  wire        hit_ro    = i_cmd_valid && ((i_cmd_code == ocl_pkg::CMD_LV_THRESHOLD) ||
                                          (i_cmd_code == ocl_pkg::CMD_LV_RESPONSE));
  wire        all_ph    = (i_cmd_phase == ocl_pkg::PHASE_ALL) && !ph1;
  wire        wr_lim    = hit_lim && i_cmd_write;
  wire        rd_lim    = hit_lim && !i_cmd_write;

  // Per-phase write permission checks
  wire        up_chg    = i_cmd_wdata[15:8] != ocl_pkg::LIM_UPPER_RESET;
  wire        b7_bad    = (i_cmd_wdata[ocl_pkg::LIM_BIT7_POS] != mant_ff[ocl_pkg::LIM_BIT7_POS]) &&
                          !(ph3 || ph4);
  wire        b6_bad    = (i_cmd_wdata[ocl_pkg::LIM_BIT6_POS] != mant_ff[ocl_pkg::LIM_BIT6_POS]) &&
                          ph1;
  wire        lim_bad   = all_ph ? up_chg : (up_chg || b7_bad || b6_bad);
  wire        wr_bad    = (wr_lim && lim_bad) || (hit_ro && i_cmd_write);

  // All-phase split of the stack value
  wire [8:0]  st2       = {1'b0, i_cmd_wdata[7:0]} + 9'd1;
  wire [8:0]  st4       = {1'b0, i_cmd_wdata[7:0]} + 9'd2;
  wire [7:0]  per_ph2   = st2[8:1];
  wire [7:0]  per_ph4   = {1'b0, st4[8:2]};
  wire [7:0]  per_ph3   = canon(bin_stack3(i_cmd_wdata[7:0]));
  wire [7:0]  split_val = ph2 ? per_ph2 : (ph3 ? per_ph3 : per_ph4);

  // Applied threshold: highest band whose lower bound the stored mantissa reaches
  assign o_oc_level = bin_phase({1'b0, mant_ff});

  // Read data
  wire [10:0] prod      = mant_ff * ph_mult;
  wire        rd_all    = rd_lim && all_ph;
  wire [15:0] lv_rsp    = {8'h00, 1'b0, i_uv_response[ocl_pkg::RSP_ACT_POS],
                           i_uv_response[5:3], 1'b0, i_uv_response[1:0]};
  wire [15:0] rd_val    = (i_cmd_code == ocl_pkg::CMD_LV_THRESHOLD) ? i_uv_fault_limit :
                          (i_cmd_code == ocl_pkg::CMD_LV_RESPONSE) ? lv_rsp :
                          rd_all ? {5'h00, prod} : {8'h00, mant_ff};

  // Mantissa next value: restore, then accepted writes
  always_comb
  begin
    nxt_mant = mant_ff;
    if (i_nvm_restore)
      nxt_mant = canon(i_nvm_level);
    else if (wr_lim && !lim_bad)
      nxt_mant = all_ph ? split_val : i_cmd_wdata[7:0];
  end

  // Limit storage and command answer
  always_ff @(posedge i_clk)
  begin
    if (i_reset)
    begin
      mant_ff   <= ocl_pkg::LIM_MANT_RESET;
      done_ff   <= 1'b0;
      nack_ff   <= 1'b0;
      silent_ff <= 1'b0;
      rdata_ff  <= 16'h0000;
    end
    else
    begin
      mant_ff   <= nxt_mant;
      done_ff   <= hit_lim || hit_ro;
      nack_ff   <= wr_bad;
      silent_ff <= rd_all && !i_is_primary;
      rdata_ff  <= (i_cmd_write || (rd_all && !i_is_primary)) ? 16'h0000 : rd_val;
    end
  end

  assign o_cmd_done   = done_ff;
  assign o_cmd_nack   = nack_ff;
  assign o_cmd_silent = silent_ff;
  assign o_cmd_rdata  = rdata_ff;

  // Comparator threshold: relative value, LSB given by the mode byte
  always_ff @(posedge i_clk)
  begin
    if (i_reset)
    begin
      o_lv_threshold <= 16'h0000;
      o_lv_mode      <= 8'h00;
    end
    else
    begin
      o_lv_threshold <= i_uv_fault_limit;
      o_lv_mode      <= i_vout_mode;
    end
  end

  // Fault sequencer inputs
  wire        act_en    = i_uv_response[ocl_pkg::RSP_ACT_POS];
  wire [2:0]  retry     = i_uv_response[5:3];
  wire        lv_cond   = i_in_current_limit && i_vout_below_lv;
  wire [31:0] dly_cyc   = (i_uv_response[1:0] == 2'h0) ? 32'(ocl_pkg::DLY_2US_CYC) :
                          (i_uv_response[1:0] == 2'h1) ? 32'(ocl_pkg::DLY_16US_CYC) :
                          (i_uv_response[1:0] == 2'h2) ? 32'(DLY64_CYC) : 32'(DLY256_CYC);
  wire        cnt_end   = (cnt_ff == 32'h00000001);
  wire        declare   = (state_ff == ocl_pkg::OCL_DELAY) && lv_cond && cnt_end;

  // Fault sequencer next state; codes other than hiccup latch off
  always_comb
  begin
    nxt_state = state_ff;
    nxt_cnt   = cnt_ff;
    case (state_ff)
      ocl_pkg::OCL_IDLE:
      begin
        if (lv_cond && act_en)
        begin
          nxt_state = ocl_pkg::OCL_DELAY;
          nxt_cnt   = dly_cyc;
        end
      end
      ocl_pkg::OCL_DELAY:
      begin
        if (!lv_cond)
        begin
          nxt_state = ocl_pkg::OCL_IDLE;
          nxt_cnt   = 32'h00000000;
        end
        else if (cnt_end)
        begin
          nxt_state = (retry == ocl_pkg::RETRY_HICCUP) ? ocl_pkg::OCL_HICCUP : ocl_pkg::OCL_OFF;
          nxt_cnt   = 32'(HICCUP_CYC);
        end
        else
          nxt_cnt = cnt_ff - 32'h00000001;
      end
      ocl_pkg::OCL_OFF:
      begin
        if (i_clear_faults)
          nxt_state = ocl_pkg::OCL_IDLE;
      end
      ocl_pkg::OCL_HICCUP:
      begin
        if (cnt_end)
          nxt_state = ocl_pkg::OCL_IDLE;
        else
          nxt_cnt = cnt_ff - 32'h00000001;
      end
      default:
        nxt_state = ocl_pkg::OCL_IDLE;
    endcase
  end

  // Fault sequencer registers
  always_ff @(posedge i_clk)
  begin
    if (i_reset)
    begin
      state_ff <= ocl_pkg::OCL_IDLE;
      cnt_ff   <= 32'h00000000;
    end
    else
    begin
      state_ff <= nxt_state;
      cnt_ff   <= nxt_cnt;
    end
  end

  assign o_output_off = (state_ff == ocl_pkg::OCL_OFF) || (state_ff == ocl_pkg::OCL_HICCUP);

  // Sticky flags; a set in the clearing cycle wins
  always_ff @(posedge i_clk)
  begin
    if (i_reset)
    begin
      cml_ff  <= 1'b0;
      ivd_ff  <= 1'b0;
      oc_ff   <= 1'b0;
      iout_ff <= 1'b0;
      ocuv_ff <= 1'b0;
    end
    else
    begin
      cml_ff  <= wr_bad  || (cml_ff  && !i_clear_faults);
      ivd_ff  <= wr_bad  || (ivd_ff  && !i_clear_faults);
      oc_ff   <= declare || (oc_ff   && !i_clear_faults);
      iout_ff <= declare || (iout_ff && !i_clear_faults);
      ocuv_ff <= declare || (ocuv_ff && !i_clear_faults);
    end
  end

  assign o_status_cml     = cml_ff;
  assign o_status_ivd     = ivd_ff;
  assign o_status_oc      = oc_ff;
  assign o_status_iout    = iout_ff;
  assign o_status_ocuv    = ocuv_ff;
  // Alert only ever pulls low; the pin is released otherwise
  assign o_smbalert_n_out = 1'b0;
  assign o_smbalert_n_oe  = oc_ff || cml_ff;

  // Checks
  bad_write_nack_a: assert property (@(posedge i_clk) disable iff (i_reset)
    (wr_lim && ph1 && up_chg) |=> (o_cmd_nack && o_status_ivd && o_status_cml && $stable(mant_ff)))
    else $error("upper byte change not refused");
  bit7_guard_a: assert property (@(posedge i_clk) disable iff (i_reset)
    (wr_lim && !all_ph && ph2 && !i_nvm_restore && b7_bad) |=> $stable(mant_ff[7]))
    else $error("bit 7 changed with two phases");
  split_two_a: assert property (@(posedge i_clk) disable iff (i_reset)
    (wr_lim && all_ph && ph2 && !up_chg && !i_nvm_restore) |=> (mant_ff == ($past(i_cmd_wdata[7:0]) / 2
      + $past(i_cmd_wdata[0]))))
    else $error("two-phase split wrong");
  split_four_a: assert property (@(posedge i_clk) disable iff (i_reset)
    (wr_lim && all_ph && ph4 && !up_chg && !i_nvm_restore) |=> (mant_ff == ({1'b0, $past(i_cmd_wdata[7:0])}
      + 9'd2) >> 2))
    else $error("four-phase split wrong");
  secondary_quiet_a: assert property (@(posedge i_clk) disable iff (i_reset)
    (rd_lim && all_ph && !i_is_primary) |=> (o_cmd_silent && o_cmd_rdata == 16'h0000))
    else $error("secondary answered all-phase read");
  primary_product_a: assert property (@(posedge i_clk) disable iff (i_reset)
    (rd_lim && all_ph && i_is_primary && ph3) |=> (o_cmd_rdata == 16'($past(mant_ff)) * 16'd3))
    else $error("all-phase read not multiplied");
  mirror_read_a: assert property (@(posedge i_clk) disable iff (i_reset)
    (i_cmd_valid && !i_cmd_write && i_cmd_code == ocl_pkg::CMD_LV_THRESHOLD) |=>
      (o_cmd_rdata == $past(i_uv_fault_limit)))
    else $error("threshold read is not the mirror");
  sequence lv_declared_s;
    declare ##1 (o_status_oc && o_status_iout && o_status_ocuv);
  endsequence
  fault_flags_a: assert property (@(posedge i_clk) disable iff (i_reset)
    declare |-> lv_declared_s)
    else $error("fault flags not set");
  alert_low_a: assert property (@(posedge i_clk) disable iff (i_reset)
    declare |=> (o_smbalert_n_oe && !o_smbalert_n_out))
    else $error("alert not driven on fault");
  delay_clear_a: assert property (@(posedge i_clk) disable iff (i_reset)
    (state_ff == ocl_pkg::OCL_DELAY && !lv_cond) |=> (state_ff == ocl_pkg::OCL_IDLE && !o_output_off))
    else $error("delay not cleared when fault vanished");
  latch_off_a: assert property (@(posedge i_clk) disable iff (i_reset)
    (declare && retry == ocl_pkg::RETRY_LATCH) |=> (state_ff == ocl_pkg::OCL_OFF) ##1
      (o_output_off || $past(i_clear_faults)))
    else $error("latch-off not entered");
  ro_write_a: assert property (@(posedge i_clk) disable iff (i_reset)
    (hit_ro && i_cmd_write) |=> (o_cmd_nack && o_cmd_done))
    else $error("read-only write accepted");
endmodule

// ---- verilog/ocl_pkg.sv ----
package ocl_pkg;
  // Command codes; all but the undervoltage fault limit are handled by this block
  localparam logic [7:0] CMD_UV_FAULT_LIMIT = 8'h44;
  localparam logic [7:0] CMD_OC_FAULT_LIMIT = 8'h46;
  localparam logic [7:0] CMD_LV_THRESHOLD   = 8'h48;
  localparam logic [7:0] CMD_LV_RESPONSE    = 8'h49;
  localparam logic [7:0] PHASE_ALL          = 8'hFF;

  // Limit register layout
  localparam int          LIM_BIT7_POS     = 7;
  localparam int          LIM_BIT6_POS     = 6;
  localparam logic [7:0]  LIM_UPPER_RESET  = 8'h00;
  localparam logic [7:0]  LIM_MANT_RESET   = 8'h1C;

  // Response byte layout (copied from the undervoltage response)
  localparam int          RSP_ACT_POS      = 6;
  localparam int          RSP_RETRY_LSB    = 3;
  localparam logic [2:0]  RETRY_LATCH      = 3'h0;
  localparam logic [2:0]  RETRY_HICCUP     = 3'h7;

  // Phase-count field encoding: 0 stands for four phases
  localparam logic [1:0]  PH_ONE           = 2'h1;
  localparam logic [1:0]  PH_TWO           = 2'h2;
  localparam logic [1:0]  PH_THREE         = 2'h3;
  localparam logic [1:0]  PH_FOUR          = 2'h0;

  // Timing
  localparam int CLK_PERIOD_NS  = 10;
  localparam int DLY_2US_NS     = 2000;
  localparam int DLY_16US_NS    = 16000;
  localparam int DLY_64US_NS    = 64000;
  localparam int DLY_256US_NS   = 256000;
  localparam int HICCUP_MS      = 52;
  localparam int DLY_2US_CYC    = DLY_2US_NS / CLK_PERIOD_NS;
  localparam int DLY_16US_CYC   = DLY_16US_NS / CLK_PERIOD_NS;
  localparam int DLY_64US_CYC   = DLY_64US_NS / CLK_PERIOD_NS;
  localparam int DLY_256US_CYC  = DLY_256US_NS / CLK_PERIOD_NS;
  localparam int HICCUP_CYC     = HICCUP_MS * 1000000 / CLK_PERIOD_NS;

  // Fault sequencer, Gray along idle-delay-off and hiccup-idle; delay-hiccup and off-idle flip both bits
  typedef enum logic [1:0] {
    OCL_IDLE   = 2'b00,
    OCL_DELAY  = 2'b01,
    OCL_OFF    = 2'b11,
    OCL_HICCUP = 2'b10
  } ocl_state_type;
endpackage
